// ---- pkg/wer_params.svh ----
// Purpose: offsets, field positions, reset values for the wake-up event router
// Assumes: included by bare name
// Notes: byte addresses on a 32-bit avalon-mm slave
`ifndef WER_PARAMS_SVH
`define WER_PARAMS_SVH

`define WER_NUM_EVENTS 16
// register byte offsets
`define WER_OFF_ENABLE 8'h00
`define WER_OFF_EDGE 8'h04
`define WER_OFF_STATUS 8'h08
`define WER_OFF_CLEAR 8'h0c
`define WER_OFF_MASK 8'h10
`define WER_OFF_LEVEL 8'h14
`define WER_OFF_MODE 8'h18
// reset values
`define WER_RST_ENABLE 16'h0000
`define WER_RST_EDGE 16'h0000
`define WER_RST_MASK 16'h0000
// event positions
`define WER_EV_WAKE0 0
`define WER_EV_RESET_PIN 4
`define WER_EV_ALARM 5
`define WER_EV_RTC 6
`define WER_EV_WATCHDOG 7
// events 0..4 reach every low-power mode, 5..6 the deeper ones only while the oscillator runs, 7..15 sleep only
`define WER_DEEP_REACH 16'h007f
// low-power mode field position
`define WER_MODE_LSB 0

`endif

// ---- pkg/wer_pkg.sv ----
// Purpose: types for the wake-up event router
// Assumes: constants come from wer_params.svh
// Notes: mode codes follow enum order
package wer_pkg;
    // low-power mode the core is in
    typedef enum logic [2:0] {
        WER_RUN,
        WER_SLEEP,
        WER_DEEP_SLEEP,
        WER_POWER_DOWN,
        WER_DEEP_POWER_DOWN
    } wer_mode_t;
endpackage : wer_pkg

// ---- rtl/wer_router.sv ----
// Purpose: wake-up event router with avalon-mm register slave
// Assumes: event inputs are asynchronous and pass two flip-flops
// Notes: event map: 0..3 wake pins, 4 reset pin, 5 alarm, 6 rtc,
//        7 watchdog, 8 brown-out, 9..10 can, 11 quadrature encoder,
//        12 ethernet, 13..14 usb ports, 15 combined timer outputs
//
// Behaviour
// - enabled internal, peripheral and wake pin events merge into one interrupt request to the processor.
// - a wake-up output goes to the core and clock control unit for leaving any low-power mode.
// - each event is set edge or level sensitive and is detected by its own choice.
// - each event has its own enable and a disabled event raises neither interrupt nor wake-up.
// - wake pins and the reset pin, when enabled, wake from all four low-power modes and may interrupt.
// - alarm and real-time clock events wake from sleep always, and from the three deeper modes only while the 32 kHz oscillator runs.
// - watchdog, brown-out, can, encoder, ethernet, usb and timer events wake from sleep only.
// - each peripheral except the timer gives a single line that may merge several of its flags; the four timer outputs merge here into event 15.
`timescale 1ns/1ps
`include "wer_params.svh"

module wer_router (
    input wire logic clk, // 100 mhz system clock
    input wire logic reset, // synchronous, active high
    input wire logic [3:0] wake_pin_input, // external wake-up pins
    input wire logic reset_pin, // reset pin event
    input wire logic alarm_event, // alarm timer
    input wire logic rtc_event, // real-time clock
    input wire logic rtc_osc_running, // 32 khz oscillator is running
    input wire logic windowed_watchdog, // watchdog interrupt
    input wire logic brownout_detector, // brown-out interrupt
    input wire logic [1:0] can_controllers, // can interrupts
    input wire logic quadrature_encoder, // encoder interrupt
    input wire logic ethernet_event, // ethernet signal
    input wire logic [1:0] usb_event, // usb0 and usb1 signals
    input wire logic [3:0] timer_outputs, // selected combined timer outputs
    input wire logic [2:0] avs_address, // word address
    input wire logic avs_read, // read strobe
    input wire logic avs_write, // write strobe
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    output logic [1:0] avs_response, // 00 ok, 10 slave error
    output logic irq_to_controller, // interrupt to processor_interrupt_controller
    output logic wake_request, // wake-up to core and clock_control_unit
    output logic irq // status interrupt, level
);

    localparam int N = `WER_NUM_EVENTS;

    logic [N-1:0] raw_ev;
    logic [N-1:0] sync1_reg;
    logic [N-1:0] sync2_reg;
    logic [N-1:0] prev_reg;
    logic [N-1:0] enable_reg;
    logic [N-1:0] edge_reg;
    logic [N-1:0] pend_reg;
    logic [N-1:0] mask_reg;
    logic [N-1:0] active;
    logic [N-1:0] reach;
    logic [N-1:0] clr_pend;
    logic [N-1:0] clr_stat;
    logic [N-1:0] stat_reg;
    logic osc_s1_reg;
    logic osc_s2_reg;
    wer_pkg::wer_mode_t mode_reg;
    logic wr_ack_reg;
    logic rd_ack_reg;
    logic [7:0] byte_addr;
    logic wr_go;
    logic rd_go;

    // byte-lane merge for a 16-bit register
    function automatic logic [N-1:0] merge16(input logic [N-1:0] old, input logic [31:0] d, input logic [3:0] be);
        merge16 = old;
        if (be[0]) merge16[7:0] = d[7:0];
        if (be[1]) merge16[15:8] = d[15:8];
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////
    // event gathering: one line per peripheral, timer outputs merged here, other flags upstream
    assign raw_ev = {timer_outputs != 4'h0, usb_event, ethernet_event, quadrature_encoder, can_controllers,
                     brownout_detector, windowed_watchdog, rtc_event, alarm_event, reset_pin, wake_pin_input};

    // two-stage synchroniser, then edge history
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_ev;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            osc_s1_reg <= rtc_osc_running;
            osc_s2_reg <= osc_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bus
    assign byte_addr = {3'h0, avs_address, 2'b00};
    assign wr_go = avs_write && !wr_ack_reg;
    assign rd_go = avs_read && !rd_ack_reg;
    assign avs_waitrequest = !((avs_write && wr_ack_reg) || (avs_read && rd_ack_reg));
    assign clr_pend = (wr_go && byte_addr == `WER_OFF_CLEAR) ? merge16('0, avs_writedata, avs_byteenable) : '0;
    assign clr_stat = (wr_go && byte_addr == `WER_OFF_STATUS) ? merge16('0, avs_writedata, avs_byteenable) : '0;

    // configuration writes
    always_ff @(posedge clk) begin
        if (reset) begin
            enable_reg <= `WER_RST_ENABLE;
            edge_reg <= `WER_RST_EDGE;
            mask_reg <= `WER_RST_MASK;
            mode_reg <= wer_pkg::WER_RUN;
        end else if (wr_go) begin
            if (byte_addr == `WER_OFF_ENABLE) begin
                enable_reg <= merge16(enable_reg, avs_writedata, avs_byteenable);
            end else if (byte_addr == `WER_OFF_EDGE) begin
                edge_reg <= merge16(edge_reg, avs_writedata, avs_byteenable);
            end else if (byte_addr == `WER_OFF_MASK) begin
                mask_reg <= merge16(mask_reg, avs_writedata, avs_byteenable);
            end else if (byte_addr == `WER_OFF_MODE && avs_byteenable[0]) begin
                mode_reg <= wer_pkg::wer_mode_t'(avs_writedata[`WER_MODE_LSB +: 3]);
            end
        end
    end

    // one wait cycle per access, answer in the second cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ack_reg <= 1'b0;
            rd_ack_reg <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else begin
            wr_ack_reg <= wr_go;
            rd_ack_reg <= rd_go;
            if (rd_go || wr_go) begin
                avs_response <= 2'b00;
                avs_readdata <= 32'h0000_0000;
                if (byte_addr == `WER_OFF_ENABLE) begin
                    avs_readdata <= {16'h0000, enable_reg};
                end else if (byte_addr == `WER_OFF_EDGE) begin
                    avs_readdata <= {16'h0000, edge_reg};
                end else if (byte_addr == `WER_OFF_STATUS) begin
                    avs_readdata <= {16'h0000, stat_reg};
                end else if (byte_addr == `WER_OFF_CLEAR) begin
                    avs_readdata <= {16'h0000, pend_reg};
                end else if (byte_addr == `WER_OFF_MASK) begin
                    avs_readdata <= {16'h0000, mask_reg};
                end else if (byte_addr == `WER_OFF_LEVEL) begin
                    avs_readdata <= {16'h0000, sync2_reg};
                end else if (byte_addr == `WER_OFF_MODE) begin
                    avs_readdata <= {29'h0, mode_reg};
                end else begin
                    avs_response <= 2'b10; // unmapped
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-event detection
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_ev
            // edge latches until cleared; set wins over clear
            always_ff @(posedge clk) begin
                if (reset) begin
                    pend_reg[gi] <= 1'b0;
                end else if (edge_reg[gi] && enable_reg[gi] && sync2_reg[gi] && !prev_reg[gi]) begin
                    pend_reg[gi] <= 1'b1;
                end else if (clr_pend[gi] || !edge_reg[gi]) begin
                    pend_reg[gi] <= 1'b0;
                end
            end
            // level follows input, edge uses pending, gated by enable
            assign active[gi] = enable_reg[gi] && (edge_reg[gi] ? pend_reg[gi] : sync2_reg[gi]);
            // sticky status of enabled events, set wins over write-one-clear
            always_ff @(posedge clk) begin
                if (reset) begin
                    stat_reg[gi] <= 1'b0;
                end else if (active[gi]) begin
                    stat_reg[gi] <= 1'b1;
                end else if (clr_stat[gi]) begin
                    stat_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // which events may wake from the present mode
    always_comb begin
        reach = '1;
        if (mode_reg != wer_pkg::WER_RUN && mode_reg != wer_pkg::WER_SLEEP) begin
            reach = `WER_DEEP_REACH;
            if (!osc_s2_reg) begin
                reach[`WER_EV_ALARM] = 1'b0;
                reach[`WER_EV_RTC] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all registered
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_to_controller <= 1'b0;
            wake_request <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_to_controller <= |active;
            wake_request <= (mode_reg != wer_pkg::WER_RUN) && |(active & reach);
            irq <= |(stat_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_rise(int i);
        !prev_reg[i] && sync2_reg[i];
    endsequence

    a_disabled_no_irq: assert property (@(posedge clk) disable iff (reset)
        (enable_reg == '0) ##1 (enable_reg == '0) |-> !irq_to_controller)
        else $error("irq raised with every event disabled");
    a_irq_follows_active: assert property (@(posedge clk) disable iff (reset)
        |active |=> irq_to_controller)
        else $error("active event did not raise irq");
    a_edge_pending_holds: assert property (@(posedge clk) disable iff (reset)
        pend_reg[0] && edge_reg[0] && !clr_pend[0] ##1 edge_reg[0] |-> pend_reg[0])
        else $error("edge pending dropped without clear");
    a_edge_sets_pend: assert property (@(posedge clk) disable iff (reset)
        s_rise(0) and (edge_reg[0] && enable_reg[0]) |=> pend_reg[0])
        else $error("edge not latched");
    a_level_follows: assert property (@(posedge clk) disable iff (reset)
        !edge_reg[1] && enable_reg[1] |-> active[1] == sync2_reg[1])
        else $error("level event not following input");
    a_sleep_only_deep: assert property (@(posedge clk) disable iff (reset)
        mode_reg == wer_pkg::WER_POWER_DOWN && (active & `WER_DEEP_REACH) == '0 ##1
        mode_reg == wer_pkg::WER_POWER_DOWN |-> !wake_request)
        else $error("sleep-only event woke from deep mode");
    a_pin_wakes_deep: assert property (@(posedge clk) disable iff (reset)
        mode_reg == wer_pkg::WER_DEEP_POWER_DOWN && active[`WER_EV_WAKE0] |=> wake_request)
        else $error("wake pin failed to wake from deep power-down");
    a_rtc_needs_osc: assert property (@(posedge clk) disable iff (reset)
        mode_reg == wer_pkg::WER_DEEP_SLEEP && !osc_s2_reg && (active & 16'h001f) == '0 &&
        (active & 16'hff80) == '0 |=> !wake_request)
        else $error("rtc woke without oscillator");
    a_run_no_wake: assert property (@(posedge clk) disable iff (reset)
        mode_reg == wer_pkg::WER_RUN |=> !wake_request)
        else $error("wake asserted while running");

    ////////////////////////////////////////////////////////////////////////
    // bus and per-event checks
    // a request seen while its internal ack is low is taken at this edge
    sequence s_wr_taken;
        avs_write && !wr_ack_reg;
    endsequence

    sequence s_rd_taken;
        avs_read && !rd_ack_reg;
    endsequence

    // the first cycle of every access is stalled
    a_bus_stall_first: assert property (@(posedge clk) disable iff (reset)
        (avs_write && !wr_ack_reg) || (avs_read && !rd_ack_reg) |-> avs_waitrequest)
        else $error("first cycle of access not stalled");

    // a held write is answered after exactly one wait cycle
    a_wr_one_wait: assert property (@(posedge clk) disable iff (reset)
        s_wr_taken ##1 avs_write |-> !avs_waitrequest)
        else $error("write not answered after one wait");

    // a held read is answered after exactly one wait cycle
    a_rd_one_wait: assert property (@(posedge clk) disable iff (reset)
        s_rd_taken ##1 avs_read |-> !avs_waitrequest)
        else $error("read not answered after one wait");

    // the unmapped word answers with a slave error
    a_unmapped_error: assert property (@(posedge clk) disable iff (reset)
        s_rd_taken ##0 (avs_address == 3'h7) |=> avs_response == 2'b10)
        else $error("unmapped read not refused");

    // mapped words answer okay
    a_mapped_okay: assert property (@(posedge clk) disable iff (reset)
        s_rd_taken ##0 (avs_address != 3'h7) |=> avs_response == 2'b00)
        else $error("mapped read refused");

    // status interrupt rises with an unmasked status bit
    a_irq_from_status: assert property (@(posedge clk) disable iff (reset)
        (stat_reg & mask_reg) != '0 |=> irq)
        else $error("status interrupt missing");

    // status interrupt stays low with nothing unmasked
    a_irq_quiet: assert property (@(posedge clk) disable iff (reset)
        (stat_reg & mask_reg) == '0 |=> !irq)
        else $error("status interrupt without cause");

    // an active event records its status bit
    a_status_sets: assert property (@(posedge clk) disable iff (reset)
        active[0] |=> stat_reg[0])
        else $error("status bit not set");

    // a status bit holds until written with a one
    a_status_holds: assert property (@(posedge clk) disable iff (reset)
        stat_reg[0] && !clr_stat[0] |=> stat_reg[0])
        else $error("status bit dropped without clear");

    // a disabled event never becomes pending
    a_disabled_no_pend: assert property (@(posedge clk) disable iff (reset)
        !enable_reg[0] && !pend_reg[0] |=> !pend_reg[0])
        else $error("disabled event latched");

    // switching to level drops any pending edge
    a_level_drops_pend: assert property (@(posedge clk) disable iff (reset)
        !edge_reg[0] |=> !pend_reg[0])
        else $error("pending kept in level mode");

    // in sleep every active event wakes the core
    a_sleep_all_wake: assert property (@(posedge clk) disable iff (reset)
        mode_reg == wer_pkg::WER_SLEEP && active != '0 |=> wake_request)
        else $error("active event failed to wake from sleep");

    // pins and the reset pin reach the deep modes
    a_deep_pin_reach: assert property (@(posedge clk) disable iff (reset)
        mode_reg == wer_pkg::WER_DEEP_SLEEP && (active & 16'h001f) != '0 |=> wake_request)
        else $error("pin event failed to wake from deep-sleep");

    // rtc wakes from power-down while the oscillator runs
    a_rtc_with_osc: assert property (@(posedge clk) disable iff (reset)
        mode_reg == wer_pkg::WER_POWER_DOWN && osc_s2_reg && active[`WER_EV_RTC] |=> wake_request)
        else $error("rtc failed to wake with oscillator");

    // alarm alone cannot wake from deep power-down with the oscillator stopped
    a_alarm_no_osc: assert property (@(posedge clk) disable iff (reset)
        mode_reg == wer_pkg::WER_DEEP_POWER_DOWN && !osc_s2_reg && active == 16'h0020 |=> !wake_request)
        else $error("alarm woke without oscillator");

    // no active event means no wake-up
    a_idle_no_wake: assert property (@(posedge clk) disable iff (reset)
        active == '0 |=> !wake_request)
        else $error("wake-up without active event");

    // no active event means no interrupt request
    a_idle_no_irq: assert property (@(posedge clk) disable iff (reset)
        active == '0 |=> !irq_to_controller)
        else $error("interrupt without active event");

endmodule : wer_router

// ---- test/wer_partner.sv ----
// Purpose: processor side model that consumes interrupt and wake-up requests
// Assumes: one clock, synchronous active-high reset
// Notes: the core counts as awake whenever it is not in a low-power mode
`timescale 1ns/1ps

module wer_partner (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic irq_to_controller, // merged request from the router
    input wire logic wake_request, // wake-up from the router
    input wire logic own_irq_enabled, // line enabled inside the controller
    input wire logic in_low_power, // core sits in a low-power mode
    input wire logic in_sleep, // core sits in sleep, the lightest mode
    output logic core_awake // core runs again
);
    logic woke_reg;

    ////////////////////////////////////////////////////////////////////////////
    // wake by router request, or from sleep by any enabled controller line
    always_ff @(posedge clk) begin
        if (reset || !in_low_power) begin
            woke_reg <= 1'b0;
        end else if (wake_request || (in_sleep && own_irq_enabled && irq_to_controller)) begin
            woke_reg <= 1'b1;
        end
    end
    assign core_awake = !in_low_power || woke_reg;
endmodule : wer_partner

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the wake-up event router
// Assumes: one access at a time on the register bus
// Notes: random event, enable, mode and oscillator values from a fixed lfsr
`timescale 1ns/1ps

module testbench;
    logic clk, reset, reset_pin, alarm_event, rtc_event, rtc_osc_running, windowed_watchdog, brownout_detector;
    logic quadrature_encoder, ethernet_event, avs_read, avs_write, avs_waitrequest, irq_to_controller;
    logic wake_request, irq, core_awake, osc, own;
    logic [3:0] wake_pin_input, timer_outputs, avs_byteenable;
    logic [1:0] can_controllers, usb_event, avs_response, rsp;
    logic [2:0] avs_address, md, m;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] seed, v, en;
    int failures, n_tests;

    wer_router dut (.clk, .reset, .wake_pin_input, .reset_pin, .alarm_event, .rtc_event, .rtc_osc_running,
        .windowed_watchdog, .brownout_detector, .can_controllers, .quadrature_encoder, .ethernet_event,
        .usb_event, .timer_outputs, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .avs_response, .irq_to_controller, .wake_request, .irq);
    wer_partner partner (.clk, .reset, .irq_to_controller, .wake_request, .own_irq_enabled(own),
        .in_low_power(md != wer_pkg::WER_RUN), .in_sleep(md == wer_pkg::WER_SLEEP), .core_awake);

    ////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic exp_wake(input logic [15:0] a, input logic [2:0] m, input logic o);
        if (m == wer_pkg::WER_RUN) return 1'b0;
        if (m == wer_pkg::WER_SLEEP) return |a;
        return (|(a & 16'h001f)) || (o && |(a & 16'h0060));
    endfunction : exp_wake
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0);
        chk(k, 2, "bus wait cycles");
        rd = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic drive(input logic [15:0] e, input logic o);
        @(posedge clk);
        {windowed_watchdog, rtc_event, alarm_event, reset_pin, wake_pin_input} <= e[7:0];
        {ethernet_event, quadrature_encoder, can_controllers, brownout_detector} <= e[12:8];
        usb_event <= e[14:13];
        timer_outputs <= {e[15] & e[2], 2'b00, e[15]};
        rtc_osc_running <= o;
    endtask : drive
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic report_and_stop();
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset = 1'b1;
        md = 3'h0;
        own = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        failures = 0;
        n_tests = 0;
        seed = 16'h004d;
        drive(16'h0000, 1'b0);
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        // reset values and an unmapped word
        for (int a = 0; a < 7; a += 2) begin
            bus(1'b0, 3'(a), 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        bus(1'b1, 3'h7, 32'hffff);
        chk(rsp, 2'b10, "unmapped write");
        bus(1'b0, 3'h7, 32'h0);
        chk(rsp, 2'b10, "unmapped read response");
        chk(rd, 32'h0, "unmapped read data");
        avs_byteenable = 4'h1;
        bus(1'b1, 3'h4, 32'hffff);
        avs_byteenable = 4'hf;
        bus(1'b0, 3'h4, 32'h0);
        chk(rd, 32'h00ff, "byte lane");
        // edge event latched, masked status, clear
        bus(1'b1, 3'h4, 32'h0001);
        bus(1'b1, 3'h0, 32'h0001);
        bus(1'b1, 3'h1, 32'h0001);
        bus(1'b1, 3'h2, 32'hffff);
        drive(16'h0001, 1'b0);
        drive(16'h0000, 1'b0);
        settle(6);
        chk(irq_to_controller, 1'b1, "edge pending");
        bus(1'b0, 3'h2, 32'h0);
        chk(rd[0], 1'b1, "status set");
        settle(2);
        chk(irq, 1'b1, "status irq");
        bus(1'b1, 3'h3, 32'h0001);
        bus(1'b1, 3'h2, 32'h0001);
        settle(3);
        chk({irq_to_controller, irq}, 2'b00, "cleared");
        bus(1'b1, 3'h0, 32'h0);
        drive(16'h0001, 1'b0);
        drive(16'h0000, 1'b0);
        settle(6);
        bus(1'b1, 3'h0, 32'h0001);
        settle(4);
        chk(irq_to_controller, 1'b0, "disabled edge");
        bus(1'b1, 3'h1, 32'h0);
        // random level events across every mode
        repeat (60) begin
            md <= 3'h0; // back to run so the core model forgets the last wake-up
            seed = lfsr(seed);
            en = seed;
            seed = lfsr(seed);
            v = seed;
            seed = lfsr(seed);
            m = 3'(seed[2:0] % 3'h5);
            osc = seed[3];
            bus(1'b1, 3'h0, {16'h0, en});
            bus(1'b1, 3'h6, {29'h0, m});
            drive(v, osc);
            settle(6);
            @(posedge clk);
            md <= m;
            own <= seed[4];
            settle(1);
            chk(irq_to_controller, |(v & en), "merged irq");
            chk(wake_request, exp_wake(v & en, m, osc), "wake reach");
            chk(core_awake, (m == wer_pkg::WER_RUN) || exp_wake(v & en, m, osc) ||
                (m == wer_pkg::WER_SLEEP && own && |(v & en)), "core wake");
            bus(1'b0, 3'h5, 32'h0);
            chk(rd, {16'h0, v}, "level view");
        end
        report_and_stop();
    end
endmodule : testbench
